// *** src/ultd_decode.sv ***
// pure resistor-enable decode from the five transceiver control fields.
// assumes the caller registers the outputs; no state lives here.
`default_nettype none

module ultd_decode (
   // control fields
   input wire logic [1:0] speed_select,
   input wire logic termination_select,
   input wire logic [1:0] operating_mode_field,
   input wire logic plus_line_pulldown_bit,
   input wire logic minus_line_pulldown_bit,
   // resistor enables
   output logic plus_pullup_enable,
   output logic plus_pulldown_enable,
   output logic minus_pulldown_enable,
   output logic highspeed_termination_enable
);
   import ultd_pkg::*;

   // ===================================================================
   // decode
   logic driving;
   logic signalling_opm;

   // non-driving mode kills every resistor regardless of other fields
   assign driving = (operating_mode_field != ULTD_OPM_NONDRV);
   // only normal and no-stuffing modes count as active signalling
   assign signalling_opm = (operating_mode_field == ULTD_OPM_NORMAL) ||
                           (operating_mode_field == ULTD_OPM_NOSTUFF);

   // pull-downs follow their bits unless three-stated
   always_comb begin
      plus_pulldown_enable = driving && plus_line_pulldown_bit;
      minus_pulldown_enable = driving && minus_line_pulldown_bit;
   end

   // hs termination: hs select, term select low, active mode
   always_comb begin
      highspeed_termination_enable = (speed_select == ULTD_SPD_HS) &&
         !termination_select && signalling_opm;
   end

   // pull-up only for a peripheral role (dp pull-down clear), fs or
   // chirp; low speed peripheral pull-up on dm is not modelled here
   always_comb begin
      plus_pullup_enable = termination_select && !plus_line_pulldown_bit &&
         signalling_opm && ((speed_select == ULTD_SPD_HS) ||
         (speed_select == ULTD_SPD_FS));
   end

endmodule

`default_nettype wire

// *** src/ultd_pkg.sv ***
// package for the line termination decoder: register map, field layout,
// reset value, field encodings and signalling mode codes.
// assumes a single 40 MHz core clock and a plain strobe register port.
`default_nettype none

package ultd_pkg;

   // ===================================================================
   // register port geometry
   localparam int ULTD_AW = 4;
   localparam int ULTD_DW = 8;

   // ===================================================================
   // register offsets
   localparam logic [3:0] ULTD_ADDR_CTRL = 4'h0; // read / write
   localparam logic [3:0] ULTD_ADDR_SET = 4'h4; // write ones to set
   localparam logic [3:0] ULTD_ADDR_CLR = 4'h8; // write ones to clear
   localparam logic [3:0] ULTD_ADDR_STAT = 4'hc; // read only

   // ===================================================================
   // control register fields
   localparam int ULTD_SPD_LSB = 0;
   localparam int ULTD_TERM_BIT = 2;
   localparam int ULTD_OPM_LSB = 3;
   localparam int ULTD_PLUS_PD_BIT = 5;
   localparam int ULTD_MINUS_PD_BIT = 6;
   localparam logic [7:0] ULTD_CTRL_MASK = 8'h7f;
   // power-up: full speed select, both pull-down bits set
   localparam logic [7:0] ULTD_CTRL_RESET = 8'h61;

   // ===================================================================
   // status register fields
   localparam int ULTD_ST_PU_BIT = 0;
   localparam int ULTD_ST_PPD_BIT = 1;
   localparam int ULTD_ST_MPD_BIT = 2;
   localparam int ULTD_ST_HST_BIT = 3;
   localparam int ULTD_ST_MODE_LSB = 4;

   // ===================================================================
   // field encodings
   localparam logic [1:0] ULTD_SPD_HS = 2'h0;
   localparam logic [1:0] ULTD_SPD_FS = 2'h1;
   localparam logic [1:0] ULTD_SPD_LS = 2'h2;
   localparam logic [1:0] ULTD_SPD_FSLS = 2'h3;
   localparam logic [1:0] ULTD_OPM_NORMAL = 2'h0;
   localparam logic [1:0] ULTD_OPM_NONDRV = 2'h1;
   localparam logic [1:0] ULTD_OPM_NOSTUFF = 2'h2;
   localparam logic [1:0] ULTD_OPM_RSVD = 2'h3;

   // ===================================================================
   // recognised signalling modes, reported in the status register
   typedef enum logic [3:0] {
      ULTD_M_UNLISTED = 4'h0,
      ULTD_M_THREE_STATE = 4'h1,
      ULTD_M_POWER_UP = 4'h2,
      ULTD_M_HOST_CHIRP_TEST = 4'h3,
      ULTD_M_HOST_HS = 4'h4,
      ULTD_M_HOST_FS = 4'h5,
      ULTD_M_HOST_LS = 4'h6,
      ULTD_M_HOST_RESUME = 4'h7,
      ULTD_M_PERI_CHIRP = 4'h8,
      ULTD_M_PERI_HS = 4'h9,
      ULTD_M_PERI_FS = 4'ha,
      ULTD_M_PERI_TEST = 4'hb,
      ULTD_M_OTG_CHIRP = 4'hc,
      ULTD_M_OTG_HS = 4'hd,
      ULTD_M_OTG_FS = 4'he,
      ULTD_M_OTG_TEST = 4'hf
   } ultd_mode_t;

endpackage

`default_nettype wire

// *** src/ultd_top.sv ***
// line termination decoder: control register, status register and
// registered resistor enables for a usb otg transceiver.
// assumes a same-clock register master on a plain strobe port.
// assumes the link alone picks the combination; reserved field values
// are stored as written and decoded conservatively.
//
// Functional notes
// - pull-up only for peripheral fs or chirp
// - pull-downs follow bits, three-state forces off
// - hs termination: hs, term low, active
// - non-driving mode clears all four enables
// - host chirp: pull-downs plus hs termination
// - host high speed: pull-downs plus termination
// - host full speed: pull-downs only
// - host low speed variants: pull-downs only
// - host resume: pull-downs only
// - host test j/k: pull-downs plus termination
// - peripheral chirp: pull-up only
// - peripheral high speed: termination only
// - peripheral full speed: pull-up only
// - peripheral test j/k: termination only
`default_nettype none

module ultd_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic [ultd_pkg::ULTD_AW-1:0] reg_addr,
   input wire logic [ultd_pkg::ULTD_DW-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [ultd_pkg::ULTD_DW-1:0] reg_rdata,
   // resistor enables
   output logic plus_pullup_enable,
   output logic plus_pulldown_enable,
   output logic minus_pulldown_enable,
   output logic highspeed_termination_enable
);
   import ultd_pkg::*;

   // ===================================================================
   // control register state
   // map: ctrl is read/write; the set and clear aliases let the link
   // flip one field without a read-modify-write, which matters when
   // chirp timing leaves no room for a read turn; status is read only,
   // and writes to it or to unmapped offsets are dropped silently
   logic [7:0] ctrl;
   logic [7:0] next_ctrl;
   logic [7:0] wmask;

   // only defined bits are ever stored; bit 7 reads zero
   assign wmask = reg_wdata & ULTD_CTRL_MASK;

   // the link owns every field; this block only stores them
   always_comb begin
      next_ctrl = ctrl;
      if (reg_write) begin
         case (reg_addr)
            ULTD_ADDR_CTRL: begin
               next_ctrl = wmask;
            end
            ULTD_ADDR_SET: begin
               next_ctrl = ctrl | wmask;
            end
            ULTD_ADDR_CLR: begin
               next_ctrl = ctrl & ~wmask;
            end
            default: begin
               next_ctrl = ctrl;
            end
         endcase
      end
   end

   // reset leaves both pull-down bits set, so an attached peripheral
   // sees a host-like idle until the link takes over
   // reset lands in the power-up combination
   always_ff @(posedge core_clk) begin
      if (rst) begin
         ctrl <= ULTD_CTRL_RESET;
      end else begin
         ctrl <= next_ctrl;
      end
   end

   // ===================================================================
   // field split of the value about to be stored
   logic [1:0] n_speed;
   logic n_term;
   logic [1:0] n_opm;
   logic n_plus_pd;
   logic n_minus_pd;

   // hazard: decoding from ctrl instead would put the enables one cycle
   // behind the stored fields, so status and pins would disagree with
   // the control read-back for a cycle after every write
   // decode from next_ctrl so the enables move on the write edge itself
   always_comb begin
      n_speed = next_ctrl[ULTD_SPD_LSB +: 2];
      n_term = next_ctrl[ULTD_TERM_BIT];
      n_opm = next_ctrl[ULTD_OPM_LSB +: 2];
      n_plus_pd = next_ctrl[ULTD_PLUS_PD_BIT];
      n_minus_pd = next_ctrl[ULTD_MINUS_PD_BIT];
   end

   // ===================================================================
   // resistor decode
   logic dec_pu;
   logic dec_ppd;
   logic dec_mpd;
   logic dec_hst;

   // the decode is kept in its own module so the pure table logic can
   // be checked apart from the register plumbing around it
   // one pure function covers every table row
   ultd_decode u_decode (
      .speed_select(n_speed),
      .termination_select(n_term),
      .operating_mode_field(n_opm),
      .plus_line_pulldown_bit(n_plus_pd),
      .minus_line_pulldown_bit(n_minus_pd),
      .plus_pullup_enable(dec_pu),
      .plus_pulldown_enable(dec_ppd),
      .minus_pulldown_enable(dec_mpd),
      .highspeed_termination_enable(dec_hst)
   );

   // ===================================================================
   // signalling mode classification for status readback
   ultd_mode_t mode;
   ultd_mode_t next_mode;
   logic hs_t0;
   logic fs_t1;

   assign hs_t0 = (n_speed == ULTD_SPD_HS) && !n_term;
   assign fs_t1 = (n_speed == ULTD_SPD_FS) && n_term;

   // the mode code is for software only and never feeds the enables;
   // rows that the link may program but that name no known state
   // (reserved operating mode, dp pull-down alone) read as unlisted
   // rather than being guessed at
   // names the table row in force; anything else reads as unlisted
   always_comb begin
      next_mode = ULTD_M_UNLISTED;
      if (n_opm == ULTD_OPM_NONDRV) begin
         next_mode = ULTD_M_THREE_STATE;
      end else begin
         case ({n_plus_pd, n_minus_pd})
            2'h3: begin
               // host role: both pull-downs set
               if (hs_t0 && n_opm == ULTD_OPM_NOSTUFF) begin
                  next_mode = ULTD_M_HOST_CHIRP_TEST;
               end else if (hs_t0 && n_opm == ULTD_OPM_NORMAL) begin
                  next_mode = ULTD_M_HOST_HS;
               end else if (n_speed == ULTD_SPD_FS && !n_term &&
                            n_opm == ULTD_OPM_NORMAL) begin
                  next_mode = ULTD_M_POWER_UP;
               end else if (n_speed[0] && n_term &&
                            n_opm == ULTD_OPM_NORMAL) begin
                  next_mode = ULTD_M_HOST_FS;
               end else if (fs_t1 && n_opm == ULTD_OPM_NOSTUFF) begin
                  next_mode = ULTD_M_HOST_RESUME;
               end else if (n_speed == ULTD_SPD_LS && n_term &&
                            (n_opm == ULTD_OPM_NORMAL ||
                             n_opm == ULTD_OPM_NOSTUFF)) begin
                  next_mode = ULTD_M_HOST_LS;
               end else begin
                  next_mode = ULTD_M_UNLISTED;
               end
            end
            2'h0: begin
               // peripheral role: no pull-downs
               if (n_speed == ULTD_SPD_HS && n_term &&
                   n_opm == ULTD_OPM_NOSTUFF) begin
                  next_mode = ULTD_M_PERI_CHIRP;
               end else if (hs_t0 && n_opm == ULTD_OPM_NORMAL) begin
                  next_mode = ULTD_M_PERI_HS;
               end else if (fs_t1 && (n_opm == ULTD_OPM_NORMAL ||
                            n_opm == ULTD_OPM_NOSTUFF)) begin
                  next_mode = ULTD_M_PERI_FS;
               end else if (hs_t0 && n_opm == ULTD_OPM_NOSTUFF) begin
                  next_mode = ULTD_M_PERI_TEST;
               end else begin
                  next_mode = ULTD_M_UNLISTED;
               end
            end
            2'h1: begin
               // otg peripheral: only the dm pull-down kept
               if (n_speed == ULTD_SPD_HS && n_term &&
                   n_opm == ULTD_OPM_NOSTUFF) begin
                  next_mode = ULTD_M_OTG_CHIRP;
               end else if (hs_t0 && n_opm == ULTD_OPM_NORMAL) begin
                  next_mode = ULTD_M_OTG_HS;
               end else if (fs_t1 && (n_opm == ULTD_OPM_NORMAL ||
                            n_opm == ULTD_OPM_NOSTUFF)) begin
                  next_mode = ULTD_M_OTG_FS;
               end else if (hs_t0 && n_opm == ULTD_OPM_NOSTUFF) begin
                  next_mode = ULTD_M_OTG_TEST;
               end else begin
                  next_mode = ULTD_M_UNLISTED;
               end
            end
            default: begin
               // dp pull-down alone is no documented row
               next_mode = ULTD_M_UNLISTED;
            end
         endcase
      end
   end

   // ===================================================================
   // registered enables and mode
   logic next_pu;
   logic next_ppd;
   logic next_mpd;
   logic next_hst;

   // every enable leaves a flip-flop so the analog switches never see
   // decode glitches while several control bits change in one write
   // enables are a pure function of the stored fields, registered once
   always_comb begin
      next_pu = dec_pu;
      next_ppd = dec_ppd;
      next_mpd = dec_mpd;
      next_hst = dec_hst;
   end

   // the power-up row needs no decode, so the reset values are written
   // out rather than taken from the decoder
   // reset values equal the decode of the reset control value
   always_ff @(posedge core_clk) begin
      if (rst) begin
         plus_pullup_enable <= 1'b0;
         plus_pulldown_enable <= 1'b1;
         minus_pulldown_enable <= 1'b1;
         highspeed_termination_enable <= 1'b0;
         mode <= ULTD_M_POWER_UP;
      end else begin
         plus_pullup_enable <= next_pu;
         plus_pulldown_enable <= next_ppd;
         minus_pulldown_enable <= next_mpd;
         highspeed_termination_enable <= next_hst;
         mode <= next_mode;
      end
   end

   // ===================================================================
   // read data path
   logic [7:0] next_rdata;
   logic [7:0] status;

   // limitation: status reports what is driven, so a status read right
   // after a write already returns the updated enables
   // status shows the enables actually driven, not the request
   always_comb begin
      status = 8'h00;
      status[ULTD_ST_PU_BIT] = plus_pullup_enable;
      status[ULTD_ST_PPD_BIT] = plus_pulldown_enable;
      status[ULTD_ST_MPD_BIT] = minus_pulldown_enable;
      status[ULTD_ST_HST_BIT] = highspeed_termination_enable;
      status[ULTD_ST_MODE_LSB +: 4] = mode;
   end

   // read data stands one cycle only, zero otherwise, so a stale
   // value can never be mistaken for a fresh answer
   always_comb begin
      next_rdata = 8'h00;
      if (reg_read) begin
         case (reg_addr)
            ULTD_ADDR_CTRL: begin
               next_rdata = ctrl;
            end
            ULTD_ADDR_SET: begin
               next_rdata = ctrl;
            end
            ULTD_ADDR_CLR: begin
               next_rdata = ctrl;
            end
            ULTD_ADDR_STAT: begin
               next_rdata = status;
            end
            default: begin
               next_rdata = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= next_rdata;
      end
   end

endmodule

`default_nettype wire

// *** verif/ultd_link_model.sv ***
// link controller model: programs the control fields over the strobe port.
// assumes one clock; every change lands by nonblocking after a rising edge.
`default_nettype none

module ultd_link_model (
   // clock
   input wire logic core_clk,
   // register port, master side
   output logic [ultd_pkg::ULTD_AW-1:0] reg_addr,
   output logic [ultd_pkg::ULTD_DW-1:0] reg_wdata,
   output logic reg_write,
   output logic reg_read,
   input wire logic [ultd_pkg::ULTD_DW-1:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   import ultd_pkg::*;

   // ===================================================================
   // idle bus at time zero
   initial begin
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end

   // one-cycle write; the link alone picks the combination
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_write <= 1'b1;
      @(posedge core_clk);
      reg_write <= 1'b0;
      // released lines do not keep the old value
      reg_addr <= ~a;
      reg_wdata <= ~d;
   endtask

   // one-cycle read; data stand only in the following cycle
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge core_clk);
      reg_read <= 1'b0;
      reg_addr <= ~a;
      #1;
      d = reg_rdata;
   endtask
endmodule

`default_nettype wire

// *** verif/ultd_monitor.sv ***
// checker for the line termination decoder, bound onto ultd_top.
// assumes enables switch on the ctrl write edge, reads answer next cycle.
`default_nettype none

module ultd_monitor (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // register port
   input wire logic [ultd_pkg::ULTD_AW-1:0] reg_addr,
   input wire logic [ultd_pkg::ULTD_DW-1:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [ultd_pkg::ULTD_DW-1:0] reg_rdata,
   // resistor enables
   input wire logic plus_pullup_enable,
   input wire logic plus_pulldown_enable,
   input wire logic minus_pulldown_enable,
   input wire logic highspeed_termination_enable
);
   timeunit 1ns;
   timeprecision 1ps;
   import ultd_pkg::*;

   // ===================================================================
   // helper: last cycle's write data split into fields
   logic [7:0] wd_q;
   logic [1:0] spd;
   logic [1:0] opm;
   logic trm;
   logic act;
   logic [3:0] en;
   always_ff @(posedge core_clk) begin
      wd_q <= reg_wdata;
   end
   assign spd = wd_q[1:0];
   assign trm = wd_q[2];
   assign opm = wd_q[4:3];
   // only these two modes enable pull-up or termination; reserved mode counts as idle here
   assign act = (opm == ULTD_OPM_NORMAL) || (opm == ULTD_OPM_NOSTUFF);
   // enables packed in status order
   assign en = {highspeed_termination_enable, minus_pulldown_enable,
      plus_pulldown_enable, plus_pullup_enable};

   default clocking mon_cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // ===================================================================
   // a write to the control register
   sequence ctrl_wr;
      reg_write && (reg_addr == ULTD_ADDR_CTRL);
   endsequence

   AST_OFF: assert property (
      ctrl_wr ##0 reg_wdata[4:3] == ULTD_OPM_NONDRV |=> en == 4'h0)
      else $error("enables left on in three-state mode");
   AST_PD: assert property (ctrl_wr |=> en[2:1] ==
      ((opm == ULTD_OPM_NONDRV) ? 2'h0 : {wd_q[6], wd_q[5]}))
      else $error("pull-downs do not follow their bits");
   AST_HS: assert property (ctrl_wr |=> en[3] ==
      (spd == ULTD_SPD_HS && !trm && act))
      else $error("termination enable wrong");
   AST_PU: assert property (ctrl_wr |=> en[0] ==
      (trm && !wd_q[5] && act && !spd[1])) else $error("pull-up wrong");
   AST_PWR: assert property ($fell(rst) |-> en == 4'h6)
      else $error("enables after reset wrong");
   AST_HOLD: assert property (!reg_write |=> $stable(en))
      else $error("enables moved without a write");
   AST_STAT: assert property (
      reg_read && reg_addr == ULTD_ADDR_STAT |=> reg_rdata[3:0] == $past(en))
      else $error("status differs");
   // a later write may legally move the enables in the second cycle
   AST_HOSTFS: assert property (
      ctrl_wr ##0 reg_wdata[6:0] == 7'h67
      |=> en == 4'h6 ##1 (en == 4'h6 || $past(reg_write)))
      else $error("host full speed enables wrong");
endmodule

`default_nettype wire

// *** verif/ultd_top_tb.sv ***
// self-checking bench for ultd_top: walks every documented combination.
// assumes the link model drives the port and ultd_monitor is bound in.
`default_nettype none

module ultd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ultd_pkg::*;

   // ===================================================================
   // signals
   logic core_clk;
   logic rst;
   logic [ULTD_AW-1:0] reg_addr;
   logic [ULTD_DW-1:0] reg_wdata;
   logic [ULTD_DW-1:0] reg_rdata;
   logic reg_write;
   logic reg_read;
   logic pu;
   logic ppd;
   logic mpd;
   logic hs;
   logic [3:0] en;
   logic [7:0] rd_v;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   assign en = {hs, mpd, ppd, pu};

   // mode code, ctrl byte, then enables {hs, mpd, ppd, pu}
   logic [15:0] tab [21] = '{
      16'h16f0, 16'h10d0, 16'h2616,
      16'h370e, 16'h460e, 16'h5676, 16'h5656,
      16'h7756, 16'h6666, 16'h6766,
      16'h8141, 16'h9008, 16'ha051,
      16'ha151, 16'hb108,
      16'hc545, 16'he455, 16'he555, 16'hd40c, 16'hf50c,
      16'h0382}; // reserved mode

   ultd_top i_ultd_top (.core_clk(core_clk), .rst(rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
      .reg_read(reg_read), .reg_rdata(reg_rdata),
      .plus_pullup_enable(pu), .plus_pulldown_enable(ppd),
      .minus_pulldown_enable(mpd), .highspeed_termination_enable(hs));

   ultd_link_model link (.core_clk(core_clk), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata));

   // ===================================================================
   // clock, and a ceiling well above the ~120 cycles the run needs
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 2000) begin
         error_cnt++;
         test_done();
      end
   end

   task automatic check(input string what, input logic [7:0] seen,
      input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic pulse_reset(input int n);
      rst <= 1'b1;
      repeat (n) @(posedge core_clk);
      rst <= 1'b0;
      #1;
      check("reset enables", {4'h0, en}, 8'h06);
   endtask

   // ===================================================================
   // main sequence
   initial begin
      rst = 1'b1;
      pulse_reset(10);
      link.rd(ULTD_ADDR_CTRL, rd_v);
      check("ctrl reset", rd_v, ULTD_CTRL_RESET);
      // every row of the table, then its status copy
      for (int i = 0; i < 21; i++) begin
         link.wr(ULTD_ADDR_CTRL, tab[i][11:4]);
         #1;
         check("enables", {4'h0, en}, {4'h0, tab[i][3:0]});
         link.rd(ULTD_ADDR_STAT, rd_v);
         check("status", rd_v, {tab[i][15:12], tab[i][3:0]});
      end
      // set and clear aliases switch enables in the write cycle
      link.wr(ULTD_ADDR_CTRL, 8'h05);
      link.wr(ULTD_ADDR_SET, 8'h60);
      #1;
      check("after set", {4'h0, en}, 8'h06);
      link.wr(ULTD_ADDR_CLR, 8'h60);
      #1;
      check("after clear", {4'h0, en}, 8'h01);
      // writes to the read-only status must not move anything
      link.wr(ULTD_ADDR_STAT, 8'h00);
      #1;
      check("status write", {4'h0, en}, 8'h01);
      link.wr(ULTD_ADDR_CTRL, 8'h85);
      link.rd(ULTD_ADDR_CTRL, rd_v);
      check("ctrl bit 7", rd_v, 8'h05);
      link.rd(4'h2, rd_v);
      check("unmapped read", rd_v, 8'h00);
      // reset again in mid-run, then read back the power-up state
      @(posedge core_clk);
      pulse_reset(2);
      link.rd(ULTD_ADDR_STAT, rd_v);
      check("status after reset", rd_v, 8'h26);
      link.rd(ULTD_ADDR_CTRL, rd_v);
      check("ctrl after reset", rd_v, ULTD_CTRL_RESET);
      test_done();
   end
endmodule

bind ultd_top ultd_monitor i_ultd_monitor (.core_clk(core_clk), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rdata(reg_rdata),
   .plus_pullup_enable(plus_pullup_enable),
   .plus_pulldown_enable(plus_pulldown_enable),
   .minus_pulldown_enable(minus_pulldown_enable),
   .highspeed_termination_enable(highspeed_termination_enable));

`default_nettype wire
